/* File: core/lfc_pkg.sv */
// constants, types and carriers for the flash LED mode control block
// Function
// RULE_01: pump runs in exactly one ratio: bypass, one-and-a-half or double.
// RULE_02: low sink headroom steps pump up; analog prediction input steps it down.
// RULE_03: soft start limits battery current at pump enable and every ratio change.
// RULE_04: at double ratio a sink still short is excluded until power-on.
// RULE_05: in host-controlled modes the failing sink paths are readable as status.
// RULE_06: open-LED scan starts the first time the pump reaches double ratio.
// RULE_07: normal mode flash block total reaches 450mA in 15 or 30mA steps.
// RULE_08: normal mode uses 15mA steps below 240mA, 30mA steps above.
// RULE_09: host-controlled modes drive the three flash sinks together from one setting.
// RULE_10: normal mode aux sinks set individually, up to 37.5mA in 2.5mA steps.
// RULE_11: soft flash mode flash block total reaches 480mA in 1.875mA steps.
// RULE_12: soft flash mode aux sinks set individually up to 160mA.
// RULE_13: host-controlled modes take strobe and preview from register bits or pins.
// RULE_14: hard mode 1 decodes strobe and preview pin codes onto all six sinks.
// RULE_15: controller in hard mode 1 keeps total current at or below 480mA; the code sets no limit, the top strobe code gives 900mA.
// RULE_16: hard mode 2 sets flash block from flash pins in 60mA steps.
// RULE_17: hard mode 2 sets aux block from preview pins, six levels plus 37.5mA.
// RULE_18: hard mode 2 sink current follows pulse-width gating on the control pins.
// RULE_19: hard variant choice is a fixed configuration, not changed at run time.
// RULE_20: straps pick mode: hard strap high is hard, else bit1 picks normal/soft.
// RULE_21: hard modes read all six control pins active low, floating means inactive.
// RULE_22: over-temperature switches all sinks off until the indication clears.
// RULE_23: all external control pins are synchronised before decoding.
// RULE_24: power-on reset clears open-LED faults and returns pump to bypass.
package lfc_pkg;
  typedef logic [8:0] lfc_level_t; // sink current in 0.625mA units

  localparam int NUM_SINKS     = 6;
  localparam int SYNC_W        = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_START_US = 50;
  localparam int SOFT_START_CYC = (SOFT_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] SS_LOAD = 10'(SOFT_START_CYC);
  localparam logic [2:0] SETTLE_CYC = 3'h4;

  localparam logic [4:0] NORM_FL_CODE_MAX    = 5'h17;
  localparam logic [4:0] NORM_FL_FINE_CODES  = 5'h10;
  localparam lfc_level_t NORM_FL_FINE_UNITS  = 9'h008;
  localparam lfc_level_t NORM_FL_COARSE_UNITS = 9'h010;
  localparam lfc_level_t NORM_AUX_STEP       = 9'h004;
  localparam lfc_level_t SOFT_FL_MAX         = 9'h100;
  localparam lfc_level_t SOFT_AUX_STEP       = 9'h004;
  localparam logic [6:0] SOFT_AUX_CODE_MAX   = 7'h40;
  localparam lfc_level_t HF1_STROBE_BASE     = 9'h010;
  localparam lfc_level_t HF1_STROBE_STEP     = 9'h020;
  localparam lfc_level_t HF1_PREV_BASE       = 9'h010;
  localparam lfc_level_t HF1_PREV_STEP       = 9'h010;
  localparam lfc_level_t HF2_FL_STEP         = 9'h020;
  localparam lfc_level_t HF2_AUX_OFFSET      = 9'h002;
  localparam lfc_level_t HF2_AUX_STEP        = 9'h004;
  localparam lfc_level_t HF2_AUX_TOP         = 9'h03c;
  localparam logic [2:0] HF2_AUX_TOP_CODE    = 3'h7;
  localparam logic [5:0] FAULT_RST           = 6'h00;
  localparam logic [SYNC_W-1:0] SYNC_RST     = 16'h003f;

  typedef enum logic [2:0] {
    PUMP_BYPASS = 3'b001,
    PUMP_X1P5   = 3'b010,
    PUMP_X2     = 3'b100
  } lfc_ratio_e;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_SOFT   = 4'b0010,
    MODE_HARD1  = 4'b0100,
    MODE_HARD2  = 4'b1000
  } lfc_mode_e;

  typedef struct packed {
    logic strobe_in_flash_bit2;
    logic soft_select_flash_bit1;
    logic flash_code_bit0;
    logic serial_clock_preview_bit2;
    logic serial_data_preview_bit1;
    logic preview_in_bit0;
  } lfc_pins_s;

  typedef struct packed {
    logic [4:0] norm_flash_code;
    logic [4:0] norm_torch_code;
    logic [3:0] norm_aux_a;
    logic [3:0] norm_aux_b;
    logic [3:0] norm_aux_c;
    lfc_level_t soft_flash_code;
    lfc_level_t soft_torch_code;
    logic [6:0] soft_aux_a;
    logic [6:0] soft_aux_b;
    logic [6:0] soft_aux_c;
    logic       strobe_from_pin;
    logic       preview_from_pin;
    logic       strobe_reg;
    logic       preview_reg;
  } lfc_host_cfg_s;

  typedef struct packed {
    lfc_level_t flash_sink_a;
    lfc_level_t flash_sink_b;
    lfc_level_t flash_sink_c;
    lfc_level_t aux_sink_a;
    lfc_level_t aux_sink_b;
    lfc_level_t aux_sink_c;
  } lfc_sinks_s;
endpackage

/* File: core/lfc_sync3.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module lfc_sync3
  import lfc_pkg::*;
#(
  parameter int              W       = SYNC_W,
  parameter logic [W-1:0]    RST_VAL = '0
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        s1_reg[i]   <= RST_VAL[i];
        s2_reg[i]   <= RST_VAL[i];
        s3_reg[i]   <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end
      else
      begin
        s1_reg[i] <= async_in[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        // the first stage is never compared, only the settled pair
        if (s2_reg[i] == s3_reg[i])
          sync_out[i] <= s3_reg[i];
      end
    end
  end
endmodule

/* File: core/lfc_core.sv */
// flash LED mode control: mode decode, sink levels, pump ratio and open-LED faults
`timescale 1ns/100ps
module lfc_core
  import lfc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          hard_mode_strap,
  input  wire logic          hard_variant2_cfg,
  input  wire lfc_pins_s     ctl_pins,
  input  wire lfc_host_cfg_s host_cfg,
  input  wire logic [5:0]    sink_low_headroom,
  input  wire logic          pump_down_request,
  input  wire logic          over_temp,
  output lfc_sinks_s         sink_levels,
  output lfc_ratio_e         pump_ratio,
  output logic               soft_start_active,
  output logic [5:0]         open_led_fault,
  output logic [5:0]         failing_path_status,
  output logic               scan_started,
  output lfc_mode_e          op_mode
);
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] syn;
  lfc_pins_s         pins_s;
  logic [5:0]        headroom_s;
  logic              hard_s;
  logic              down_s;
  logic              ot_s;
  logic              variant_s;
  logic [2:0]        settle_reg;
  logic              ready_reg;
  logic              variant_reg;
  lfc_mode_e         mode_next;
  lfc_level_t        lvl_next [NUM_SINKS];
  lfc_level_t        lvl_reg  [NUM_SINKS];
  logic [5:0]        sink_on;
  logic              pump_en;
  logic              pump_en_q;
  logic [9:0]        ss_reg;
  logic              need_up;
  lfc_ratio_e        ratio_reg;
  lfc_ratio_e        ratio_next;
  logic [5:0]        fault_reg;
  logic [5:0]        fault_next;
  logic              scan_reg;
  logic [5:0]        status_reg;
  logic              flash_on;
  logic              preview_on;
  logic [2:0]        strobe_v;
  logic [2:0]        prev_v;

  assign raw_in = {hard_variant2_cfg, over_temp, pump_down_request, hard_mode_strap,
                   sink_low_headroom, ctl_pins};

  lfc_sync3 #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (raw_in),
    .sync_out (syn)
  ); // RULE_23

  assign pins_s     = syn[5:0];
  assign headroom_s = syn[11:6];
  assign hard_s     = syn[12];
  assign down_s     = syn[13];
  assign ot_s       = syn[14];
  assign variant_s  = syn[15];

  // sinks stay dark until the synchronisers hold real pin levels
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      settle_reg <= 3'h0;
      ready_reg  <= 1'b0;
    end
    else if (!ready_reg)
    begin
      settle_reg <= settle_reg + 3'h1;
      ready_reg  <= (settle_reg == SETTLE_CYC);
    end
  end

  // variant is taken once after settling and then frozen
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      variant_reg <= 1'b0;
    else if (!ready_reg && settle_reg == SETTLE_CYC)
      variant_reg <= variant_s; // RULE_19
  end

  always_comb
  begin
    if (hard_s)
      mode_next = variant_reg ? MODE_HARD2 : MODE_HARD1; // RULE_20
    else if (pins_s.soft_select_flash_bit1)
      mode_next = MODE_SOFT; // RULE_20
    else
      mode_next = MODE_NORMAL; // RULE_20
  end

  // hard modes: pins are active low, so an idle pulled-up pin decodes to zero
  assign strobe_v = ~{pins_s.strobe_in_flash_bit2, pins_s.soft_select_flash_bit1,
                      pins_s.flash_code_bit0}; // RULE_21
  assign prev_v   = ~{pins_s.serial_clock_preview_bit2, pins_s.serial_data_preview_bit1,
                      pins_s.preview_in_bit0}; // RULE_21

  // host modes: pins are plain active-high triggers
  assign flash_on   = host_cfg.strobe_from_pin ? pins_s.strobe_in_flash_bit2
                                               : host_cfg.strobe_reg; // RULE_13
  assign preview_on = host_cfg.preview_from_pin ? pins_s.preview_in_bit0
                                                : host_cfg.preview_reg; // RULE_13

  function automatic lfc_level_t norm_fl(input logic [4:0] c);
    logic [4:0] k;
    k = (c > NORM_FL_CODE_MAX) ? NORM_FL_CODE_MAX : c; // RULE_07
    if (k <= NORM_FL_FINE_CODES)
      return lfc_level_t'(k) * NORM_FL_FINE_UNITS; // RULE_08
    return lfc_level_t'(NORM_FL_FINE_CODES) * NORM_FL_FINE_UNITS
           + (lfc_level_t'(k) - lfc_level_t'(NORM_FL_FINE_CODES)) * NORM_FL_COARSE_UNITS; // RULE_08
  endfunction

  function automatic lfc_level_t soft_aux(input logic [6:0] c);
    logic [6:0] k;
    k = (c > SOFT_AUX_CODE_MAX) ? SOFT_AUX_CODE_MAX : c;
    return lfc_level_t'(k) * SOFT_AUX_STEP; // RULE_12
  endfunction

  function automatic lfc_level_t hf2_aux(input logic [2:0] v);
    if (v == 3'h0)
      return '0;
    if (v == HF2_AUX_TOP_CODE)
      return HF2_AUX_TOP; // RULE_17
    return (lfc_level_t'(v) + HF2_AUX_OFFSET) * HF2_AUX_STEP; // RULE_17
  endfunction

  always_comb
  begin
    lfc_level_t blk;
    blk = '0;
    for (int i = 0; i < NUM_SINKS; i++)
      lvl_next[i] = '0;
    unique case (mode_next)
      MODE_NORMAL:
      begin
        if (flash_on)
          blk = norm_fl(host_cfg.norm_flash_code);
        else if (preview_on)
          blk = norm_fl(host_cfg.norm_torch_code);
        lvl_next[3] = lfc_level_t'(host_cfg.norm_aux_a) * NORM_AUX_STEP; // RULE_10
        lvl_next[4] = lfc_level_t'(host_cfg.norm_aux_b) * NORM_AUX_STEP; // RULE_10
        lvl_next[5] = lfc_level_t'(host_cfg.norm_aux_c) * NORM_AUX_STEP; // RULE_10
      end
      MODE_SOFT:
      begin
        if (flash_on)
          blk = host_cfg.soft_flash_code;
        else if (preview_on)
          blk = host_cfg.soft_torch_code;
        if (blk > SOFT_FL_MAX)
          blk = SOFT_FL_MAX; // RULE_11
        lvl_next[3] = soft_aux(host_cfg.soft_aux_a);
        lvl_next[4] = soft_aux(host_cfg.soft_aux_b);
        lvl_next[5] = soft_aux(host_cfg.soft_aux_c);
      end
      MODE_HARD1:
      begin
        // strobe outranks preview when both codes are active
        if (strobe_v != 3'h0)
          blk = HF1_STROBE_BASE + lfc_level_t'(strobe_v) * HF1_STROBE_STEP; // RULE_14
        else if (prev_v != 3'h0)
          blk = HF1_PREV_BASE + lfc_level_t'(prev_v) * HF1_PREV_STEP; // RULE_14
        for (int i = 3; i < NUM_SINKS; i++)
          lvl_next[i] = blk; // RULE_14
      end
      MODE_HARD2:
      begin
        // levels track the pins every cycle, so a pulsed pin gates the sink
        blk = lfc_level_t'(strobe_v) * HF2_FL_STEP; // RULE_16 RULE_18
        for (int i = 3; i < NUM_SINKS; i++)
          lvl_next[i] = hf2_aux(prev_v); // RULE_17 RULE_18
      end
    endcase
    for (int i = 0; i < 3; i++)
      lvl_next[i] = blk; // RULE_09
    if (ot_s || !ready_reg)
      for (int i = 0; i < NUM_SINKS; i++)
        lvl_next[i] = '0; // RULE_22
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_SINKS; i++)
        lvl_reg[i] <= '0;
      op_mode <= MODE_NORMAL;
    end
    else
    begin
      for (int i = 0; i < NUM_SINKS; i++)
        lvl_reg[i] <= lvl_next[i];
      op_mode <= mode_next;
    end
  end

  assign sink_levels = '{flash_sink_a: lvl_reg[0], flash_sink_b: lvl_reg[1],
                         flash_sink_c: lvl_reg[2], aux_sink_a: lvl_reg[3],
                         aux_sink_b: lvl_reg[4], aux_sink_c: lvl_reg[5]};

  for (genvar g = 0; g < NUM_SINKS; g++)
  begin : g_on
    assign sink_on[g] = (lvl_reg[g] != '0);
  end

  assign pump_en = |sink_on;
  // excluded sinks no longer push the ratio up
  assign need_up = |(headroom_s & sink_on & ~fault_reg); // RULE_04

  always_comb
  begin
    ratio_next = ratio_reg;
    if (!pump_en)
      ratio_next = PUMP_BYPASS;
    else if (ss_reg == 10'h000)
    begin
      // a step is never taken mid soft start, which keeps the inrush bounded
      unique case (ratio_reg)
        PUMP_BYPASS:
          if (need_up)
            ratio_next = PUMP_X1P5; // RULE_02
        PUMP_X1P5:
          if (need_up)
            ratio_next = PUMP_X2; // RULE_02
          else if (down_s)
            ratio_next = PUMP_BYPASS; // RULE_02
        PUMP_X2:
          if (down_s && !need_up)
            ratio_next = PUMP_X1P5; // RULE_02
        default:
          ratio_next = PUMP_BYPASS;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ratio_reg <= PUMP_BYPASS; // RULE_24
    else
      ratio_reg <= ratio_next; // RULE_01
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pump_en_q <= 1'b0;
      ss_reg    <= 10'h000;
    end
    else
    begin
      pump_en_q <= pump_en;
      if (pump_en && (!pump_en_q || ratio_next != ratio_reg))
        ss_reg <= SS_LOAD; // RULE_03
      else if (ss_reg != 10'h000)
        ss_reg <= ss_reg - 10'h001; // RULE_03
    end
  end

  assign soft_start_active = (ss_reg != 10'h000);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      scan_reg <= 1'b0; // RULE_24
    else if (ratio_reg == PUMP_X2)
      scan_reg <= 1'b1; // RULE_06
  end

  assign fault_next = (scan_reg && ratio_reg == PUMP_X2 && ss_reg == 10'h000)
                      ? (headroom_s & sink_on) : 6'h00; // RULE_04 RULE_06

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fault_reg <= FAULT_RST; // RULE_24
    else
      fault_reg <= fault_reg | fault_next; // RULE_04
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status_reg <= FAULT_RST;
    else if (mode_next == MODE_NORMAL || mode_next == MODE_SOFT)
      status_reg <= fault_reg; // RULE_05
    else
      status_reg <= 6'h00;
  end

  assign pump_ratio          = ratio_reg;
  assign open_led_fault      = fault_reg;
  assign failing_path_status = status_reg;
  assign scan_started        = scan_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  ratio_one_hot_a: assert property ($onehot(pump_ratio)) // RULE_01
    else $error("pump ratio not one-hot");

  step_up_a: assert property ( // RULE_02
    (ratio_reg == PUMP_BYPASS && pump_en && ss_reg == 10'h000 && need_up)
    |=> (pump_ratio == PUMP_X1P5 && soft_start_active))
    else $error("pump did not step up on low headroom");

  soft_start_hold_a: assert property ( // RULE_03
    ($changed(pump_ratio) && $past(pump_en)) |-> soft_start_active [*8])
    else $error("soft start too short after ratio change");

  fault_sticky_a: assert property ( // RULE_04
    ($past(open_led_fault) & ~open_led_fault) == 6'h00)
    else $error("latched fault cleared without reset");

  status_hard_a: assert property ( // RULE_05
    (op_mode == MODE_HARD1 || op_mode == MODE_HARD2) |-> failing_path_status == 6'h00)
    else $error("fault status shown in hard mode");

  scan_first_a: assert property ( // RULE_06
    (open_led_fault != $past(open_led_fault)) |-> ($past(scan_started) && $past(pump_ratio) == PUMP_X2))
    else $error("fault latched before scan began");

  norm_limits_a: assert property ( // RULE_07
    (op_mode == MODE_NORMAL) |-> (sink_levels.flash_sink_a <= 9'h0f0 && sink_levels.aux_sink_a <= 9'h03c))
    else $error("normal mode level above limit");

  flash_block_a: assert property ( // RULE_09
    sink_levels.flash_sink_a == sink_levels.flash_sink_b
    && sink_levels.flash_sink_b == sink_levels.flash_sink_c)
    else $error("flash sinks not driven as one block");

  soft_limit_a: assert property ( // RULE_11
    (op_mode == MODE_SOFT) |-> sink_levels.flash_sink_a <= 9'h100)
    else $error("soft flash level above limit");

  hard2_idle_a: assert property ( // RULE_18
    (mode_next == MODE_HARD2 && strobe_v == 3'h0 && ready_reg && !ot_s)
    |=> sink_levels.flash_sink_a == 9'h000)
    else $error("hard mode 2 flash on with idle pins");

  over_temp_a: assert property ( // RULE_22
    ot_s |=> sink_levels == '0)
    else $error("sinks on during over-temperature");

  reach_x2_c: cover property (pump_ratio == PUMP_BYPASS ##[1:1000] pump_ratio == PUMP_X2);
  fault_latch_c: cover property ($rose(|open_led_fault));
  hard1_strobe_c: cover property (op_mode == MODE_HARD1 && sink_levels.aux_sink_c != 9'h000);
  step_down_c: cover property (pump_ratio == PUMP_X2 ##1 pump_ratio == PUMP_X1P5);
endmodule

/* File: tb/lfc_load_model.sv */
// far-side model: led load headroom and pulled-up open-drain control pins
`timescale 1ns/100ps
module lfc_load_model
  import lfc_pkg::*;
(
  input  wire lfc_sinks_s  levels,
  input  wire lfc_ratio_e  ratio,
  input  wire logic [5:0]  need_x2,
  input  wire logic [5:0]  open_mask,
  input  wire lfc_pins_s   pin_oe_n,
  output lfc_pins_s        pins,
  output logic [5:0]       low_headroom
);
  logic [5:0] lit;

  // drivers only pull low; a released pin floats up to the inactive level
  assign pins = pin_oe_n;
  assign lit = {levels.aux_sink_c != '0, levels.aux_sink_b != '0, levels.aux_sink_a != '0,
                levels.flash_sink_c != '0, levels.flash_sink_b != '0, levels.flash_sink_a != '0};
  // an open led never gains headroom, whatever the ratio
  assign low_headroom = lit & (open_mask | (need_x2 & {6{ratio != PUMP_X2}}));
endmodule

/* File: tb/lfc_core_tb_top.sv */
// self-checking bench for the flash led mode control block
`timescale 1ns/100ps
module lfc_core_tb_top
  import lfc_pkg::*;
;
  logic          core_clk;
  logic          rst;
  logic          hard_mode_strap;
  logic          hard_variant2_cfg;
  lfc_pins_s     ctl_pins;
  lfc_pins_s     pin_oe_n;
  lfc_host_cfg_s host_cfg;
  logic [5:0]    sink_low_headroom;
  logic          pump_down_request;
  logic          over_temp;
  logic [5:0]    need_x2;
  logic [5:0]    open_mask;
  lfc_sinks_s    sink_levels;
  lfc_ratio_e    pump_ratio;
  logic          soft_start_active;
  logic [5:0]    open_led_fault;
  logic [5:0]    failing_path_status;
  logic          scan_started;
  lfc_mode_e     op_mode;
  int            errors;
  int            tests_run;

  lfc_core i_lfc_core (.core_clk(core_clk), .rst(rst), .hard_mode_strap(hard_mode_strap),
    .hard_variant2_cfg(hard_variant2_cfg), .ctl_pins(ctl_pins), .host_cfg(host_cfg),
    .sink_low_headroom(sink_low_headroom), .pump_down_request(pump_down_request), .over_temp(over_temp),
    .sink_levels(sink_levels), .pump_ratio(pump_ratio), .soft_start_active(soft_start_active),
    .open_led_fault(open_led_fault), .failing_path_status(failing_path_status),
    .scan_started(scan_started), .op_mode(op_mode));

  lfc_load_model i_lfc_load_model (.levels(sink_levels), .ratio(pump_ratio), .need_x2(need_x2),
    .open_mask(open_mask), .pin_oe_n(pin_oe_n), .pins(ctl_pins), .low_headroom(sink_low_headroom));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_sinks(input logic [8:0] f, input logic [8:0] a, input logic [8:0] b, input logic [8:0] c);
    chk(sink_levels.flash_sink_a, f, "flash sink a");
    chk(sink_levels.flash_sink_b, f, "flash sink b");
    chk(sink_levels.flash_sink_c, f, "flash sink c");
    chk(sink_levels.aux_sink_a, a, "aux sink a");
    chk(sink_levels.aux_sink_b, b, "aux sink b");
    chk(sink_levels.aux_sink_c, c, "aux sink c");
  endtask

  // codes are active pin levels; only the driven bits pull low
  task automatic set_pins(input logic [2:0] fl, input logic [2:0] pv);
    pin_oe_n = ~{fl, pv};
    cyc(8);
  endtask

  task automatic do_reset(input logic v2);
    rst = 1'b1;
    hard_variant2_cfg = v2;
    cyc(6);
    rst = 1'b0;
    cyc(9);
  endtask

  task automatic chk_rst_state();
    chk(9'(pump_ratio), 9'(PUMP_BYPASS), "ratio after reset");
    chk(9'(open_led_fault), 9'h000, "faults after reset");
    chk(9'(scan_started), 9'h000, "scan after reset");
  endtask

  task automatic wait_ratio(input lfc_ratio_e r);
    int n;
    n = 0;
    while (pump_ratio !== r && n < 700)
    begin
      cyc(1);
      n++;
    end
    chk(9'(pump_ratio), 9'(r), "pump ratio");
    chk(9'(soft_start_active), 9'h001, "soft start at step");
  endtask

  task automatic t_normal();
    logic [4:0] codes [5] = '{5'h01, 5'h10, 5'h11, 5'h17, 5'h1f};
    logic [8:0] exp [5] = '{9'h008, 9'h080, 9'h090, 9'h0f0, 9'h0f0};
    set_pins(3'b010, 3'b000);
    chk(9'(op_mode), 9'(MODE_NORMAL), "normal mode");
    host_cfg.strobe_reg = 1'b1;
    host_cfg.norm_aux_a = 4'hf;
    host_cfg.norm_aux_b = 4'h1;
    host_cfg.norm_aux_c = 4'h7;
    for (int i = 0; i < 5; i++)
    begin
      host_cfg.norm_flash_code = codes[i];
      cyc(2);
      chk_sinks(exp[i], 9'h03c, 9'h004, 9'h01c);
    end
    host_cfg.strobe_reg = 1'b0;
    host_cfg.preview_reg = 1'b1;
    host_cfg.norm_torch_code = 5'h05;
    cyc(2);
    chk(sink_levels.flash_sink_a, 9'h028, "normal torch level");
    host_cfg.strobe_reg = 1'b1;
    host_cfg.preview_reg = 1'b0;
  endtask

  task automatic t_soft();
    set_pins(3'b000, 3'b000);
    chk(9'(op_mode), 9'(MODE_SOFT), "soft mode");
    host_cfg.soft_flash_code = 9'h100;
    host_cfg.soft_aux_a = 7'h40;
    host_cfg.soft_aux_b = 7'h64;
    host_cfg.soft_aux_c = 7'h01;
    cyc(2);
    chk_sinks(9'h100, 9'h100, 9'h100, 9'h004);
    host_cfg.soft_flash_code = 9'h003;
    cyc(2);
    chk_sinks(9'h003, 9'h100, 9'h100, 9'h004);
    host_cfg.strobe_reg = 1'b0;
    host_cfg.strobe_from_pin = 1'b1;
    cyc(2);
    chk(sink_levels.flash_sink_b, 9'h003, "strobe pin high");
    set_pins(3'b100, 3'b000);
    chk(sink_levels.flash_sink_b, 9'h000, "strobe pin low");
    host_cfg.preview_from_pin = 1'b1;
    host_cfg.soft_torch_code = 9'h005;
    cyc(2);
    chk(sink_levels.flash_sink_c, 9'h005, "preview pin high");
    set_pins(3'b100, 3'b001);
    chk(sink_levels.flash_sink_c, 9'h000, "preview pin low");
  endtask

  // the pin codes drive all six sinks alike, so the top strobe code puts 900mA in total
  task automatic t_hard1();
    logic [8:0] e;
    host_cfg = '0;
    hard_mode_strap = 1'b1;
    hard_variant2_cfg = 1'b1;
    set_pins(3'b000, 3'b000);
    chk(9'(op_mode), 9'(MODE_HARD1), "hard mode 1");
    chk_sinks(9'h000, 9'h000, 9'h000, 9'h000);
    for (int v = 1; v < 8; v++)
    begin
      set_pins(3'(v), 3'b000);
      e = 9'(16 + 32 * v);
      chk_sinks(e, e, e, e);
      set_pins(3'b000, 3'(v));
      e = 9'(16 + 16 * v);
      chk_sinks(e, e, e, e);
    end
    set_pins(3'b001, 3'b111);
    chk_sinks(9'h030, 9'h030, 9'h030, 9'h030);
    over_temp = 1'b1;
    cyc(8);
    chk_sinks(9'h000, 9'h000, 9'h000, 9'h000);
    over_temp = 1'b0;
    cyc(8);
    chk_sinks(9'h030, 9'h030, 9'h030, 9'h030);
  endtask

  task automatic t_hard2();
    logic [8:0] a;
    do_reset(1'b1);
    set_pins(3'b000, 3'b000);
    chk(9'(op_mode), 9'(MODE_HARD2), "hard mode 2");
    for (int v = 1; v < 8; v++)
    begin
      set_pins(3'(v), 3'(v));
      a = (v == 7) ? 9'h03c : 9'((v + 2) * 4);
      chk_sinks(9'(32 * v), a, a, a);
    end
    for (int k = 0; k < 3; k++)
    begin
      set_pins(3'b111, 3'b000);
      chk_sinks(9'h0e0, 9'h000, 9'h000, 9'h000);
      set_pins(3'b000, 3'b000);
      chk_sinks(9'h000, 9'h000, 9'h000, 9'h000);
    end
  endtask

  task automatic t_pump();
    int n;
    hard_mode_strap = 1'b0;
    do_reset(1'b0);
    set_pins(3'b010, 3'b000);
    need_x2 = 6'h01;
    host_cfg.norm_flash_code = 5'h10;
    host_cfg.strobe_reg = 1'b1;
    wait_ratio(PUMP_X1P5);
    chk(9'(scan_started), 9'h000, "scan before double");
    cyc(400);
    chk(9'(pump_ratio), 9'(PUMP_X1P5), "no step in soft start");
    wait_ratio(PUMP_X2);
    cyc(3);
    chk(9'(scan_started), 9'h001, "scan at double");
    open_mask = 6'h01;
    n = 0;
    while (open_led_fault[0] !== 1'b1 && n < 700)
    begin
      cyc(1);
      n++;
    end
    chk(9'(open_led_fault), 9'h001, "open led fault");
    cyc(2);
    chk(9'(failing_path_status), 9'h001, "failing path");
    pump_down_request = 1'b1;
    wait_ratio(PUMP_X1P5);
    pump_down_request = 1'b0;
    cyc(600);
    chk(9'(pump_ratio), 9'(PUMP_X1P5), "faulted sink ignored");
    chk(9'(open_led_fault), 9'h001, "fault sticks");
    do_reset(1'b0);
    chk_rst_state();
  endtask

  task automatic end_of_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // the whole run is under 6000 cycles; allow generous slack
  initial
  begin
    #2000000;
    errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    rst = 1'b1;
    hard_mode_strap = 1'b0;
    hard_variant2_cfg = 1'b0;
    pin_oe_n = '1;
    host_cfg = '0;
    pump_down_request = 1'b0;
    over_temp = 1'b0;
    need_x2 = 6'h00;
    open_mask = 6'h00;
    errors = 0;
    tests_run = 0;
    do_reset(1'b0);
    chk_rst_state();
    t_normal();
    t_soft();
    t_hard1();
    t_hard2();
    t_pump();
    end_of_test();
  end
endmodule
